// ---- src/instr_event_addr_capture_cfg.sv ----
// The register addresses and strobed register access were left to the implementer.
`default_nettype none

module instr_event_addr_capture_cfg
  import iear_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [3:0] regAddr,
  input wire logic [63:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [63:0] regRdata_q,
  input wire fetch_event_s evt,
  output logic freeze_q
);

  // ***************************************************************
  // Configuration
  // ***************************************************************
  logic [63:0] config_q;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      config_q <= CONFIG_RESET;
    end else if (regWr && regAddr == ADDR_CONFIG) begin
      config_q <= regWdata & CONFIG_WMASK;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      freeze_q <= 1'b0;
    end else if (regWr && regAddr == ADDR_FREEZE) begin
      freeze_q <= regWdata[0];
    end
  end

  // ***************************************************************
  // Qualification pipeline
  // ***************************************************************
  fetch_event_s evt_q;
  logic hit;

  // Event delayed to line up with the registered qualifier decision
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      evt_q <= '0;
    end else begin
      evt_q <= evt;
    end
  end

  event_qualifier u_qual (
    .clk_sys(clk_sys),
    .rst(rst),
    .cfgWord(config_q),
    .evt(evt),
    .hit(hit)
  );

  // ***************************************************************
  // Capture data
  // ***************************************************************
  logic [63:0] status_q;
  logic [63:0] iaddr_q;
  logic [63:0] statusD;

  always_comb begin
    statusD = '0;
    statusD[ST_LAT_LO +: LAT_W] = evt_q.latency;
    statusD[ST_RESP_LO +: 2] = evt_q.responder;
    statusD[ST_HIT_BIT] = evt_q.bufferHit;
    statusD[ST_TLB_LO +: 3] = evt_q.tlbLevel;
    statusD[ST_VALID_BIT] = 1'b1;
  end

  // Frozen capture holds still so software reads a consistent pair
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      status_q <= '0;
      iaddr_q <= '0;
    end else if (hit && !freeze_q) begin
      status_q <= statusD;
      iaddr_q <= {evt_q.addr, 3'h0};
    end
  end

  // ***************************************************************
  // Read port
  // ***************************************************************
  // Unfrozen reads return the live register, possibly mid-update
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      regRdata_q <= '0;
    end else if (regRd) begin
      case (regAddr)
        ADDR_CONFIG: regRdata_q <= config_q;
        ADDR_STATUS: regRdata_q <= status_q;
        ADDR_IADDR: regRdata_q <= iaddr_q;
        ADDR_FREEZE: regRdata_q <= {63'h0, freeze_q};
        default: regRdata_q <= '0;
      endcase
    end else begin
      regRdata_q <= '0;
    end
  end

endmodule : instr_event_addr_capture_cfg

`default_nettype wire

// ---- src/iear_pkg.sv ----
// Functional notes
// - Mode field bits 9:8 selects off (00), fetch-miss capture (01) or TLB-miss capture (10).
// - Qualifier bits 19:16 mean a latency threshold in fetch-miss mode and a miss-type mask in TLB mode.
// - Qualifier codes 0000 to 0111 mean any latency, then at least 16, 24, 32, 64, 96, 128, 256 cycles.
// - Qualifier codes 1000 to 1111 mean at least 384, 512, 1024, 1536, 2048, 3072, 4096, 5120 cycles.
// - In fetch-miss mode, only events meeting the programmed latency threshold are recorded.
// - Each captured fetch-miss event records its measured latency with its address.
// - Capture data are consistent only while the counting freeze bit is one; software sets it first.
// - Reads of capture data while collection runs may return undefined values.
// - Fetch-miss mode records address, latency, request-buffer hit and responder type of demand misses.
// - TLB mode mask: low three bits zero disables; bit 0 first-level, bit 1 second-level, bit 2 walker.
`default_nettype none

package iear_pkg;

  // ***************************************************************
  // Register map
  // ***************************************************************
  localparam logic [3:0] ADDR_CONFIG = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h1;
  localparam logic [3:0] ADDR_IADDR = 4'h2;
  localparam logic [3:0] ADDR_FREEZE = 4'h3;
  localparam logic [63:0] CONFIG_RESET = 64'h0;
  localparam logic [63:0] CONFIG_WMASK = 64'h0000_0006_000f_034f;

  // ***************************************************************
  // Config field positions
  // ***************************************************************
  localparam int PLM_LO = 0;
  localparam int PRIV_MON_BIT = 6;
  localparam int MODE_LO = 8;
  localparam int QUAL_LO = 16;
  localparam int VIRT_MODE_LO = 33;

  // ***************************************************************
  // Status field positions
  // ***************************************************************
  localparam int LAT_W = 13;
  localparam int ST_LAT_LO = 0;
  localparam int ST_RESP_LO = 16;
  localparam int ST_HIT_BIT = 24;
  localparam int ST_TLB_LO = 28;
  localparam int ST_VALID_BIT = 31;

  typedef enum logic [1:0] {
    MODE_OFF = 2'h0,
    MODE_CACHE = 2'h1,
    MODE_TLB = 2'h2
  } capture_mode_e;

  typedef struct packed {
    logic valid;
    logic [60:0] addr;
    logic [LAT_W-1:0] latency;
    logic bufferHit;
    logic [1:0] responder;
    logic [2:0] tlbLevel;
    logic [3:0] privLevel;
    logic privileged;
    logic [1:0] virtMode;
  } fetch_event_s;

  // Threshold per qualifier code, fetch-miss mode
  function automatic logic [LAT_W-1:0] latencyThreshold(input logic [3:0] code);
    case (code)
      4'h0: latencyThreshold = 13'h0000;
      4'h1: latencyThreshold = 13'h0010;
      4'h2: latencyThreshold = 13'h0018;
      4'h3: latencyThreshold = 13'h0020;
      4'h4: latencyThreshold = 13'h0040;
      4'h5: latencyThreshold = 13'h0060;
      4'h6: latencyThreshold = 13'h0080;
      4'h7: latencyThreshold = 13'h0100;
      4'h8: latencyThreshold = 13'h0180;
      4'h9: latencyThreshold = 13'h0200;
      4'ha: latencyThreshold = 13'h0400;
      4'hb: latencyThreshold = 13'h0600;
      4'hc: latencyThreshold = 13'h0800;
      4'hd: latencyThreshold = 13'h0c00;
      4'he: latencyThreshold = 13'h1000;
      default: latencyThreshold = 13'h1400;
    endcase
  endfunction : latencyThreshold

endpackage : iear_pkg

`default_nettype wire

// ---- src/event_qualifier.sv ----
`default_nettype none

module event_qualifier
  import iear_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [63:0] cfgWord,
  input wire fetch_event_s evt,
  output logic hit
);

  logic [1:0] mode;
  logic [3:0] qual;
  logic privOk;
  logic vmOk;
  logic cacheOk;
  logic tlbOk;

  assign mode = cfgWord[MODE_LO +: 2];
  assign qual = cfgWord[QUAL_LO +: 4];
  // Privilege mask is one-hot per level; privileged-monitor events only when set
  assign privOk = |(cfgWord[PLM_LO +: 4] & evt.privLevel) &
                  (cfgWord[PRIV_MON_BIT] | ~evt.privileged);
  // Zero field accepts any virtual mode; otherwise must match
  assign vmOk = (cfgWord[VIRT_MODE_LO +: 2] == 2'h0) ||
                (cfgWord[VIRT_MODE_LO +: 2] == evt.virtMode);
  assign cacheOk = (evt.latency >= latencyThreshold(qual));
  assign tlbOk = |(qual[2:0] & evt.tlbLevel);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      hit <= 1'b0;
    end else begin
      case (mode)
        MODE_CACHE: hit <= evt.valid & cacheOk & privOk & vmOk;
        MODE_TLB: hit <= evt.valid & tlbOk & privOk & vmOk;
        default: hit <= 1'b0;
      endcase
    end
  end

endmodule : event_qualifier

`default_nettype wire

// ---- tb/iear_props.sv ----
`default_nettype none
module iear_props
  import iear_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [3:0] regAddr,
  input wire logic [63:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [63:0] regRdata_q,
  input wire logic freeze_q
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // Bus checks
  // ****
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence wrCfg; regWr && regAddr == ADDR_CONFIG; endsequence
  sequence rdCfg; regRd && regAddr == ADDR_CONFIG; endsequence
  sequence rdSt; regRd && regAddr == ADDR_STATUS && freeze_q; endsequence
  AST_IDLE: assert property (!regRd |=> regRdata_q == 64'h0) else $error("idle");
  AST_MASK: assert property (rdCfg |=> !(regRdata_q & ~CONFIG_WMASK)) else $error("m");
  AST_CFG: assert property (wrCfg ##1 !regWr ##1 rdCfg
    |=> regRdata_q == ($past(regWdata, 3) & CONFIG_WMASK)) else $error("cfg");
  AST_FRZ: assert property (regWr && regAddr == ADDR_FREEZE
    |=> freeze_q == $past(regWdata[0])) else $error("frz");
  AST_HOLD: assert property (!(regWr && regAddr == ADDR_FREEZE)
    |=> $stable(freeze_q)) else $error("hold");
  AST_UNMAP: assert property (regRd && regAddr > ADDR_FREEZE
    |=> regRdata_q == 64'h0) else $error("unmap");
  AST_RSV: assert property (regRd && regAddr == ADDR_STATUS
    |=> !(regRdata_q & 64'hffff_ffff_0efc_e000)) else $error("rsv");
  AST_STILL: assert property (rdSt ##1 rdSt
    |=> regRdata_q == $past(regRdata_q)) else $error("still");
endmodule : iear_props
bind instr_event_addr_capture_cfg iear_props i_props (.clk_sys, .rst, .regAddr, .regWdata,
  .regWr, .regRd, .regRdata_q, .freeze_q);
`default_nettype wire

// ---- tb/fetch_model.sv ----
`default_nettype none
module fetch_model
  import iear_pkg::*;
(
  input wire logic clk_sys,
  output var fetch_event_s evt
);
  timeunit 1ns;
  timeprecision 1ps;
  initial evt = '0;
  task automatic issue(input logic [60:0] a, input logic [12:0] l, input logic [2:0] t);
    @(posedge clk_sys);
    evt <= '{1'b1, a, l, 1'b1, 2'h2, t, 4'h1, 1'b0, 2'h0};
    @(posedge clk_sys);
    // Stale fields scrambled so none is leaned on
    evt <= {1'b0, ~evt[91:0]};
    repeat (3) @(posedge clk_sys);
  endtask : issue
endmodule : fetch_model
`default_nettype wire

// ---- tb/tb.sv ----
`default_nettype none
module tb
  import iear_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0, rst = 1'b1, regWr = 1'b0, regRd = 1'b0, freeze_q;
  logic [3:0] regAddr = 4'h0;
  logic [63:0] regWdata = 64'h0, regRdata_q;
  fetch_event_s evt;
  int num_errors = 0, samples_checked = 0;
  int thr[16] = '{0, 16, 24, 32, 64, 96, 128, 256, 384, 512, 1024, 1536, 2048, 3072, 4096, 5120};
  always #2.5 clk_sys = ~clk_sys;
  fetch_model i_model (.clk_sys(clk_sys), .evt(evt));
  instr_event_addr_capture_cfg i_dut (.clk_sys(clk_sys), .rst(rst), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata_q(regRdata_q), .evt(evt),
    .freeze_q(freeze_q));
  task automatic finish_test();
    $display("checked %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [63:0] d);
    @(posedge clk_sys);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask : wr
  // Two reads back to back, so frozen data is seen twice
  task automatic rd(input logic [3:0] a, input logic [63:0] e);
    @(posedge clk_sys);
    regRd <= 1'b1;
    regAddr <= a;
    for (int i = 0; i < 2; i++) begin
      @(posedge clk_sys);
      regRd <= (i == 0);
      @(negedge clk_sys);
      chk(regRdata_q, e);
    end
  endtask : rd
  initial begin
    #50us;
    num_errors++;
    finish_test();
  end
  initial begin
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    rd(ADDR_CONFIG, CONFIG_RESET);
    wr(ADDR_CONFIG, ~64'h0);
    rd(ADDR_CONFIG, CONFIG_WMASK);
    rd(4'hf, 64'h0);
    $display("regs done");
    for (int c = 0; c < 16; c++) begin
      wr(ADDR_CONFIG, 64'h101 | (64'(c) << 16));
      i_model.issue(61'(c), 13'(thr[c]), 3'h0);
      if (c > 0) i_model.issue(61'(c + 64), 13'(thr[c] - 1), 3'h0);
      wr(ADDR_FREEZE, 64'h1);
      i_model.issue(61'h7f, 13'h1fff, 3'h0);
      rd(ADDR_STATUS, 64'h8102_0000 | 64'(thr[c]));
      rd(ADDR_IADDR, 64'(c) << 3);
      wr(ADDR_FREEZE, 64'h0);
    end
    $display("threshold done");
    wr(ADDR_CONFIG, 64'h4_0201);
    i_model.issue(61'h77, 13'h5, 3'h4);
    i_model.issue(61'h88, 13'h5, 3'h3);
    wr(ADDR_CONFIG, 64'h1);
    i_model.issue(61'h99, 13'h5, 3'h4);
    wr(ADDR_FREEZE, 64'h1);
    rd(ADDR_FREEZE, 64'h1);
    rd(ADDR_IADDR, 64'h3b8);
    rd(ADDR_STATUS, 64'hc102_0005);
    wr(ADDR_FREEZE, 64'h0);
    wr(ADDR_CONFIG, 64'h2_0000_0101);
    i_model.issue(61'haa, 13'h5, 3'h0);
    wr(ADDR_CONFIG, 64'h102);
    i_model.issue(61'hbb, 13'h5, 3'h0);
    wr(ADDR_FREEZE, 64'h1);
    rd(ADDR_IADDR, 64'h3b8);
    $display("mode done");
    finish_test();
  end
endmodule : tb
`default_nettype wire
